// File: logic/pcg_defines.svh
// Register map, field positions, reset values and unit indices for the
// peripheral clock gating block. Assumes a 12-bit APB byte address.
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

// Register byte offsets
`define PCG_OFS_RUN0 12'h100
`define PCG_OFS_RUN1 12'h104
`define PCG_OFS_SLP0 12'h110
`define PCG_OFS_SLP1 12'h114
`define PCG_OFS_DSLP0 12'h120
`define PCG_OFS_DSLP1 12'h124
`define PCG_OFS_RCC 12'h060
`define PCG_OFS_ISTAT 12'h1f0
`define PCG_OFS_IMASK 12'h1f4

// Writable bits; everything else is reserved and reads zero
`define PCG_MASK_G0 32'h0111_0348
`define PCG_MASK_G1 32'h010f_1037
`define PCG_MASK_RCC 32'h0800_0000
`define PCG_MASK_IRQ 32'h0000_0003

// Reset values
`define PCG_RST_G0 32'h0000_0000
`define PCG_RST_DSLP0 32'h0000_0040
`define PCG_RST_G1 32'h0000_0000

// Gating register 0 fields
`define PCG_B0_NET 24
`define PCG_B0_PWM 20
`define PCG_B0_ADC 16
`define PCG_B0_SPD_HI 9
`define PCG_B0_SPD_LO 8
`define PCG_B0_HIB 6
`define PCG_B0_WDG 3

// Gating register 1 fields
`define PCG_B1_CMP0 24
`define PCG_B1_TMR3 19
`define PCG_B1_TMR2 18
`define PCG_B1_TMR1 17
`define PCG_B1_TMR0 16
`define PCG_B1_TWI0 12
`define PCG_B1_SSP1 5
`define PCG_B1_SSP0 4
`define PCG_B1_ASY2 2
`define PCG_B1_ASY1 1
`define PCG_B1_ASY0 0

// Run clock configuration: auto gating select bit
`define PCG_B_ACG 27

// Sample speed codes
`define PCG_SPD_500K 2'h2
`define PCG_SPD_250K 2'h1
`define PCG_SPD_125K 2'h0

// Unit index into the clock enable vector
`define PCG_NUM_UNITS 16
`define PCG_U_ASY0 0
`define PCG_U_ASY1 1
`define PCG_U_ASY2 2
`define PCG_U_SSP0 3
`define PCG_U_SSP1 4
`define PCG_U_TWI0 5
`define PCG_U_TMR0 6
`define PCG_U_TMR1 7
`define PCG_U_TMR2 8
`define PCG_U_TMR3 9
`define PCG_U_CMP0 10
`define PCG_U_WDG 11
`define PCG_U_HIB 12
`define PCG_U_ADC 13
`define PCG_U_PWM 14
`define PCG_U_NET 15

// Interrupt status bits
`define PCG_IRQ_W 2
`define PCG_I_FAULT 0
`define PCG_I_CLAMP 1

`endif

// File: logic/pcg_pkg.sv
// Types for the peripheral clock gating block.
// Assumes pcg_defines.svh is included before this package.
`include "pcg_defines.svh"
package pcg_pkg;

  // Which gating set governs the clocks
  typedef enum logic [1:0] {SET_RUN, SET_SLEEP, SET_DEEP} pcg_set_type;

  // Register state of the top module, apart from the seen_ff helper flop
  typedef struct packed {
    logic [31:0] run0;
    logic [31:0] run1;
    logic [31:0] slp0;
    logic [31:0] slp1;
    logic [31:0] dslp0;
    logic [31:0] dslp1;
    logic auto_gating_select;
    logic [`PCG_IRQ_W-1:0] mask;
    logic [31:0] prdata;
    logic [`PCG_NUM_UNITS-1:0] clk_en;
    logic [1:0] speed;
  } pcg_state_type;

  // Sticky status of the interrupt block
  typedef struct packed {
    logic [`PCG_IRQ_W-1:0] status;
  } pcg_irq_state_type;

endpackage

// File: logic/pcg_clk_gate.sv
// Glitch-free clock gate cell: enable captured while the clock is low.
// Assumes en comes from a flop of clk_in's rising-edge domain.
`timescale 1ns/1ps
module pcg_clk_gate (
  // Clock in
  input wire logic clk_in,
  // Enable from the clock domain
  input wire logic en,
  // Gated clock out
  output logic clk_out
);

  // Transparent-low latch; holds enable steady through the high phase
  logic en_lat;

  // Latch only opens while the clock is low, so no pulse is cut short
  always_latch
  begin
    if (!clk_in)
    begin
      en_lat <= en;
    end
  end

  // AND of clock and latched enable
  assign clk_out = clk_in & en_lat;

endmodule

// File: logic/pcg_irq.sv
// Sticky event status with mask and one level interrupt.
// Assumes clear strobe and data come from the APB write decode.
`timescale 1ns/1ps
module pcg_irq #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Events, one-cycle pulses
  input wire logic [W-1:0] evt_set,
  // Write-one-to-clear
  input wire logic clr_we,
  input wire logic [W-1:0] clr_data,
  // Mask, one enables
  input wire logic [W-1:0] mask,
  // Status and interrupt
  output logic [W-1:0] status,
  output logic irq
);

  // Status register and its next value
  logic [W-1:0] status_ff;
  logic [W-1:0] nxt_status;

  // Set wins over a clear in the same cycle
  always_comb
  begin
    nxt_status = status_ff;
    if (clr_we)
    begin
      nxt_status = nxt_status & ~clr_data;
    end
    nxt_status = nxt_status | evt_set;
  end

  // Status flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_ff <= '0;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  assign status = status_ff;
  // Level interrupt while any unmasked bit is set
  assign irq = |(status_ff & mask);

endmodule

// File: logic/pcg_top.sv
// Peripheral clock gating registers, set selection, bus fault check and
// gated clock outputs. Assumes an APB3 master (no pstrb) on pclk and
// power-mode levels synchronous to pclk.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "pcg_defines.svh"
module pcg_top #(
  parameter int ADDR_W = 12,
  parameter logic [1:0] MAX_SPEED = `PCG_SPD_500K
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power mode levels
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  // Peripheral access check
  input wire logic periph_req,
  input wire logic [3:0] periph_idx,
  output logic periph_fault,
  // Clock outputs
  output logic [`PCG_NUM_UNITS-1:0] unit_clk_en,
  output logic [`PCG_NUM_UNITS-1:0] unit_clk,
  output logic [1:0] sample_speed_sel,
  // Interrupt
  output logic irq
);

  // State and next state
  pcg_pkg::pcg_state_type st_ff;
  pcg_pkg::pcg_state_type nxt_st;
  // Selected gating set
  pcg_pkg::pcg_set_type sel_set;
  // Selected register pair
  logic [31:0] sel_g0;
  logic [31:0] sel_g1;
  // Bus decode
  logic wr_acc;
  logic rd_setup;
  logic [31:0] wdat;
  // Events and interrupt status
  logic [`PCG_IRQ_W-1:0] evt;
  logic [`PCG_IRQ_W-1:0] istat;
  logic clr_we;

  // Mapped address check
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == `PCG_OFS_RUN0) || (a == `PCG_OFS_RUN1) ||
               (a == `PCG_OFS_SLP0) || (a == `PCG_OFS_SLP1) ||
               (a == `PCG_OFS_DSLP0) || (a == `PCG_OFS_DSLP1) ||
               (a == `PCG_OFS_RCC) || (a == `PCG_OFS_ISTAT) ||
               (a == `PCG_OFS_IMASK);
  endfunction

  // Gating register pair to per-unit enables
  function automatic logic [`PCG_NUM_UNITS-1:0] unit_map(input logic [31:0] g0,
                                                         input logic [31:0] g1);
    logic [`PCG_NUM_UNITS-1:0] r;
    r = '0;
    r[`PCG_U_ASY0] = g1[`PCG_B1_ASY0];
    r[`PCG_U_ASY1] = g1[`PCG_B1_ASY1];
    r[`PCG_U_ASY2] = g1[`PCG_B1_ASY2];
    r[`PCG_U_SSP0] = g1[`PCG_B1_SSP0];
    r[`PCG_U_SSP1] = g1[`PCG_B1_SSP1];
    r[`PCG_U_TWI0] = g1[`PCG_B1_TWI0];
    r[`PCG_U_TMR0] = g1[`PCG_B1_TMR0];
    r[`PCG_U_TMR1] = g1[`PCG_B1_TMR1];
    r[`PCG_U_TMR2] = g1[`PCG_B1_TMR2];
    r[`PCG_U_TMR3] = g1[`PCG_B1_TMR3];
    r[`PCG_U_CMP0] = g1[`PCG_B1_CMP0];
    r[`PCG_U_WDG] = g0[`PCG_B0_WDG];
    r[`PCG_U_HIB] = g0[`PCG_B0_HIB];
    r[`PCG_U_ADC] = g0[`PCG_B0_ADC];
    r[`PCG_U_PWM] = g0[`PCG_B0_PWM];
    r[`PCG_U_NET] = g0[`PCG_B0_NET];
    unit_map = r;
  endfunction

  // Saturate a speed code at the permitted maximum
  function automatic logic [1:0] speed_sat(input logic [1:0] code);
    speed_sat = (code > MAX_SPEED) ? MAX_SPEED : code;
  endfunction

  // Set selection: sleep sets only count with auto gating on
  always_comb
  begin
    sel_set = pcg_pkg::SET_RUN;
    if (st_ff.auto_gating_select && deep_sleep_mode)
    begin
      sel_set = pcg_pkg::SET_DEEP;
    end
    else if (st_ff.auto_gating_select && sleep_mode)
    begin
      sel_set = pcg_pkg::SET_SLEEP;
    end
  end

  // Register pair of the selected set
  always_comb
  begin
    case (sel_set)
      pcg_pkg::SET_SLEEP:
      begin
        sel_g0 = st_ff.slp0;
        sel_g1 = st_ff.slp1;
      end
      pcg_pkg::SET_DEEP:
      begin
        sel_g0 = st_ff.dslp0;
        sel_g1 = st_ff.dslp1;
      end
      default:
      begin
        sel_g0 = st_ff.run0;
        sel_g1 = st_ff.run1;
      end
    endcase
  end

  // Bus phases; zero wait states, write lands in the access phase
  assign wr_acc = psel && penable && pwrite && addr_hit(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign wdat = pwdata;
  assign clr_we = wr_acc && (paddr == `PCG_OFS_ISTAT);

  // Events: ungated access, and a speed code above the maximum
  always_comb
  begin
    evt = '0;
    evt[`PCG_I_FAULT] = periph_fault;
    if (wr_acc && ((paddr == `PCG_OFS_RUN0) || (paddr == `PCG_OFS_SLP0) ||
                   (paddr == `PCG_OFS_DSLP0)))
    begin
      evt[`PCG_I_CLAMP] = wdat[`PCG_B0_SPD_HI:`PCG_B0_SPD_LO] > MAX_SPEED;
    end
  end

  // Next state: register writes, read capture, clock enables
  always_comb
  begin
    nxt_st = st_ff;
    // Reserved bits are masked off so they stay zero
    if (wr_acc)
    begin
      case (paddr)
        `PCG_OFS_RUN0: nxt_st.run0 = wdat & `PCG_MASK_G0;
        `PCG_OFS_RUN1: nxt_st.run1 = wdat & `PCG_MASK_G1;
        `PCG_OFS_SLP0: nxt_st.slp0 = wdat & `PCG_MASK_G0;
        `PCG_OFS_SLP1: nxt_st.slp1 = wdat & `PCG_MASK_G1;
        `PCG_OFS_DSLP0: nxt_st.dslp0 = wdat & `PCG_MASK_G0;
        `PCG_OFS_DSLP1: nxt_st.dslp1 = wdat & `PCG_MASK_G1;
        `PCG_OFS_RCC: nxt_st.auto_gating_select = wdat[`PCG_B_ACG];
        `PCG_OFS_IMASK: nxt_st.mask = wdat[`PCG_IRQ_W-1:0];
        default: nxt_st.auto_gating_select = st_ff.auto_gating_select;
      endcase
    end
    // Read data captured in the setup phase, stable through access
    if (rd_setup)
    begin
      case (paddr)
        `PCG_OFS_RUN0: nxt_st.prdata = st_ff.run0;
        `PCG_OFS_RUN1: nxt_st.prdata = st_ff.run1;
        `PCG_OFS_SLP0: nxt_st.prdata = st_ff.slp0;
        `PCG_OFS_SLP1: nxt_st.prdata = st_ff.slp1;
        `PCG_OFS_DSLP0: nxt_st.prdata = st_ff.dslp0;
        `PCG_OFS_DSLP1: nxt_st.prdata = st_ff.dslp1;
        `PCG_OFS_RCC: nxt_st.prdata = 32'(st_ff.auto_gating_select) << `PCG_B_ACG;
        `PCG_OFS_ISTAT: nxt_st.prdata = {{(32-`PCG_IRQ_W){1'b0}}, istat};
        `PCG_OFS_IMASK: nxt_st.prdata = {{(32-`PCG_IRQ_W){1'b0}}, st_ff.mask};
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end
    // Enables and speed follow the set in force, one cycle later
    nxt_st.clk_en = unit_map(sel_g0, sel_g1);
    nxt_st.speed = speed_sat(sel_g0[`PCG_B0_SPD_HI:`PCG_B0_SPD_LO]);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff.run0 <= `PCG_RST_G0;
      st_ff.run1 <= `PCG_RST_G1;
      st_ff.slp0 <= `PCG_RST_G0;
      st_ff.slp1 <= `PCG_RST_G1;
      st_ff.dslp0 <= `PCG_RST_DSLP0;
      st_ff.dslp1 <= `PCG_RST_G1;
      st_ff.auto_gating_select <= 1'b0;
      st_ff.mask <= '0;
      st_ff.prdata <= 32'h0000_0000;
      st_ff.clk_en <= '0;
      st_ff.speed <= `PCG_SPD_125K;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // APB answers
  assign prdata = st_ff.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);

  // Fault when the addressed unit has its clock off
  assign periph_fault = periph_req && !st_ff.clk_en[periph_idx];

  assign unit_clk_en = st_ff.clk_en;
  assign sample_speed_sel = st_ff.speed;

  // One gate cell per unit
  genvar gi;
  generate
    for (gi = 0; gi < `PCG_NUM_UNITS; gi++)
    begin : g_gate
      pcg_clk_gate u_gate (
        .clk_in(pclk),
        .en(st_ff.clk_en[gi]),
        .clk_out(unit_clk[gi])
      );
    end
  endgenerate

  // Sticky events and interrupt line
  pcg_irq #(.W(`PCG_IRQ_W)) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .evt_set(evt),
    .clr_we(clr_we),
    .clr_data(wdat[`PCG_IRQ_W-1:0]),
    .mask(st_ff.mask),
    .status(istat),
    .irq(irq)
  );

  // Helper: low until the first edge after reset release
  logic seen_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seen_ff <= 1'b0;
    end
    else
    begin
      seen_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // APB write to an address, access phase cycle only
  sequence s_wr(logic [ADDR_W-1:0] a);
    psel && penable && pwrite && (paddr == a);
  endsequence

  property p_speed_code;
    s_wr(`PCG_OFS_RUN0) ##1 (sel_set == pcg_pkg::SET_RUN) [*2]
      |-> sample_speed_sel == speed_sat($past(pwdata[`PCG_B0_SPD_HI:`PCG_B0_SPD_LO], 2));
  endproperty
  a_speed_code: assert property (p_speed_code) else $error("speed code mismatch");

  property p_speed_max;
    sample_speed_sel <= MAX_SPEED;
  endproperty
  a_speed_max: assert property (p_speed_max) else $error("speed above maximum");

  property p_hib;
    unit_clk_en[`PCG_U_HIB] == $past(sel_g0[`PCG_B0_HIB]);
  endproperty
  a_hib: assert property (p_hib) else $error("hibernation gate wrong");

  property p_wdg_fault;
    periph_req && (periph_idx == 4'(`PCG_U_WDG)) && !unit_clk_en[`PCG_U_WDG]
      |-> periph_fault ##1 istat[`PCG_I_FAULT];
  endproperty
  a_wdg_fault: assert property (p_wdg_fault) else $error("watchdog no fault");

  property p_no_false_fault;
    periph_fault |-> !unit_clk_en[periph_idx];
  endproperty
  a_no_false_fault: assert property (p_no_false_fault) else $error("false fault");

  property p_run1_reset;
    !seen_ff |-> (st_ff.run1 == `PCG_RST_G1) && (unit_clk_en == '0);
  endproperty
  a_run1_reset: assert property (p_run1_reset) else $error("run set not reset");

  property p_deep_set;
    st_ff.auto_gating_select && deep_sleep_mode |=> unit_clk_en == $past(unit_map(st_ff.dslp0, st_ff.dslp1));
  endproperty
  a_deep_set: assert property (p_deep_set) else $error("deep set not applied");

  property p_acg_off;
    !st_ff.auto_gating_select |=> unit_clk_en == $past(unit_map(st_ff.run0, st_ff.run1));
  endproperty
  a_acg_off: assert property (p_acg_off) else $error("run set not governing");

  property p_cmp0;
    s_wr(`PCG_OFS_RUN1) ##1 (sel_set == pcg_pkg::SET_RUN)
      |=> unit_clk_en[`PCG_U_CMP0] == $past(pwdata[`PCG_B1_CMP0], 2);
  endproperty
  a_cmp0: assert property (p_cmp0) else $error("comparator gate wrong");

  property p_tmr;
    s_wr(`PCG_OFS_RUN1) ##1 (sel_set == pcg_pkg::SET_RUN)
      |=> unit_clk_en[`PCG_U_TMR3:`PCG_U_TMR2] == $past(pwdata[`PCG_B1_TMR3:`PCG_B1_TMR2], 2);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer gate wrong");

  property p_reserved;
    ((st_ff.run1 & ~`PCG_MASK_G1) == 32'h0) && ((st_ff.dslp0 & ~`PCG_MASK_G0) == 32'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_dslp0_reset;
    !seen_ff |-> st_ff.dslp0 == `PCG_RST_DSLP0;
  endproperty
  a_dslp0_reset: assert property (p_dslp0_reset) else $error("deep reg 0 reset");

endmodule

// File: sim/tb_pcg_top.sv
// Self-checking bench for the peripheral clock gating block.
// Assumes pcg_defines.svh on the include path; bench is the APB master.
`timescale 1ns/1ps
`include "pcg_defines.svh"
module tb_pcg_top;
  // Clock, reset and APB
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Modes and access check
  logic sleep_mode;
  logic deep_sleep_mode;
  logic periph_req;
  logic [3:0] periph_idx;
  logic periph_fault;
  // Clock outputs and interrupt
  logic [15:0] unit_clk_en;
  logic [15:0] unit_clk;
  logic [1:0] sample_speed_sel;
  logic irq;
  // Bookkeeping
  int n_fail;
  int num_checks;
  logic [31:0] rd;
  logic err;

  pcg_top #(.ADDR_W(12), .MAX_SPEED(`PCG_SPD_500K)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .deep_sleep_mode(deep_sleep_mode), .periph_req(periph_req),
    .periph_idx(periph_idx), .periph_fault(periph_fault),
    .unit_clk_en(unit_clk_en), .unit_clk(unit_clk),
    .sample_speed_sel(sample_speed_sel), .irq(irq)
  );

  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      n_fail++;
      results();
    end
    // Answer taken at the completing edge
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Let registered enables follow a register or mode change
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // One-cycle access probe of a unit
  task automatic probe(input logic [3:0] i, input logic e);
    @(posedge pclk);
    periph_req <= 1'b1;
    periph_idx <= i;
    #1;
    chk(periph_fault, e);
    @(posedge pclk);
    periph_req <= 1'b0;
  endtask

  // Reset values
  task automatic t_reset();
    apb(1'b0, `PCG_OFS_RUN1, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `PCG_OFS_DSLP0, 32'h0);
    chk(rd, 32'h0000_0040);
    chk(unit_clk_en, 16'h0000);
    chk(sample_speed_sel, 2'h0);
  endtask

  // Run gating 1 bits, reserved bits, faults and gated clocks
  task automatic t_run1();
    int i;
    apb(1'b1, `PCG_OFS_RUN1, 32'hffff_ffff);
    apb(1'b0, `PCG_OFS_RUN1, 32'h0);
    chk(rd, 32'h010f_1037);
    settle();
    chk(unit_clk_en, 16'h07ff);
    for (i = 0; i < 11; i++)
      probe(i[3:0], 1'b0);
    // Only comparator and counter three left on
    apb(1'b1, `PCG_OFS_RUN1, 32'h0108_0000);
    settle();
    chk(unit_clk_en, 16'h0600);
    probe(4'd8, 1'b1);
    probe(4'd7, 1'b1);
    probe(4'd9, 1'b0);
    probe(4'd10, 1'b0);
    // High phase of pclk: gated clock follows only when enabled
    @(posedge pclk);
    #1;
    chk(unit_clk[9], 1'b1);
    chk(unit_clk[8], 1'b0);
    apb(1'b1, `PCG_OFS_RUN1, 32'h0);
  endtask

  // Hibernation and watchdog gates
  task automatic t_run0();
    apb(1'b1, `PCG_OFS_RUN0, 32'h0111_0048);
    settle();
    chk(unit_clk_en, 16'hf800);
    probe(4'd11, 1'b0);
    apb(1'b1, `PCG_OFS_RUN0, 32'h0);
    settle();
    chk(unit_clk_en[12], 1'b0);
    probe(4'd11, 1'b1);
  endtask

  // Speed codes and the clamp above the maximum
  task automatic t_speed();
    int c;
    apb(1'b1, `PCG_OFS_ISTAT, 32'h3);
    for (c = 2; c >= 0; c--)
    begin
      apb(1'b1, `PCG_OFS_RUN0, c << 8);
      settle();
      chk(sample_speed_sel, c[1:0]);
    end
    apb(1'b1, `PCG_OFS_RUN0, 32'h0000_0300);
    settle();
    chk(sample_speed_sel, `PCG_SPD_500K);
    // Fault bit was cleared above and no probe ran since: only the clamp event
    apb(1'b0, `PCG_OFS_ISTAT, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'b1, `PCG_OFS_ISTAT, 32'h3);
    apb(1'b1, `PCG_OFS_RUN0, 32'h0);
  endtask

  // Fault event, mask and write-one-to-clear
  task automatic t_irq();
    apb(1'b1, `PCG_OFS_IMASK, 32'h1);
    probe(4'd11, 1'b1);
    #1;
    chk(irq, 1'b1);
    apb(1'b1, `PCG_OFS_ISTAT, 32'h1);
    @(posedge pclk);
    #1;
    chk(irq, 1'b0);
    // Masked event still latches status
    apb(1'b1, `PCG_OFS_IMASK, 32'h0);
    probe(4'd0, 1'b1);
    #1;
    chk(irq, 1'b0);
    apb(1'b0, `PCG_OFS_ISTAT, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, `PCG_OFS_ISTAT, 32'h1);
  endtask

  // Set selection by power mode and auto gating
  task automatic t_modes();
    apb(1'b1, `PCG_OFS_RUN1, 32'h0001_0000);
    apb(1'b1, `PCG_OFS_SLP0, 32'h0000_0040);
    apb(1'b1, `PCG_OFS_SLP1, 32'h0002_0000);
    apb(1'b1, `PCG_OFS_DSLP1, 32'h0004_0000);
    @(posedge pclk);
    sleep_mode <= 1'b1;
    settle();
    chk(unit_clk_en, 16'h0040);
    apb(1'b1, `PCG_OFS_RCC, 32'h0800_0000);
    settle();
    chk(unit_clk_en, 16'h1080);
    @(posedge pclk);
    deep_sleep_mode <= 1'b1;
    settle();
    chk(unit_clk_en, 16'h1100);
    @(posedge pclk);
    sleep_mode <= 1'b0;
    deep_sleep_mode <= 1'b0;
    settle();
    chk(unit_clk_en, 16'h0040);
    apb(1'b1, `PCG_OFS_RCC, 32'h0);
  endtask

  // Unmapped and misaligned places are refused
  task automatic t_unmapped();
    apb(1'b0, 12'h200, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h105, 32'hffff_ffff);
    chk(err, 1'b1);
    apb(1'b0, `PCG_OFS_RUN1, 32'h0);
    chk(rd, 32'h0001_0000);
  endtask

  // Main sequence
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sleep_mode = 1'b0;
    deep_sleep_mode = 1'b0;
    periph_req = 1'b0;
    periph_idx = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_run1();
    t_run0();
    t_speed();
    t_irq();
    t_modes();
    t_unmapped();
    results();
  end
endmodule
